/* File: rtl/tcu_top.sv */
// Timer counter with two compare channels, register port and pin override.
`timescale 1ns/1ns
`include "tcu_defines.svh"
module tcu_top (
   input wire logic clk, // System clock, 100 MHz.
   input wire logic arst_n, // Asynchronous reset, active low.
   input wire logic [2:0] addr, // Register address.
   input wire logic [7:0] wdata, // Register write data.
   input wire logic wr_en, // Write strobe.
   input wire logic rd_en, // Read strobe.
   output logic [7:0] rdata, // Read data, valid the cycle after rd_en.
   input wire logic tick_in, // Source tick from the prescaler or pin.
   input wire logic [2:0] irq_ack, // Interrupt taken: overflow, A, B.
   input wire logic [1:0] port_out, // General port levels for pins A and B.
   input wire logic [1:0] port_dir, // Port direction bits for pins A and B.
   output logic [2:0] irq_req, // Interrupt requests: overflow, A, B.
   output tcu_pkg::tcu_pin_t pin_a, // Compare output pin A.
   output tcu_pkg::tcu_pin_t pin_b, // Compare output pin B.
   output logic top_hit, // Counter stands at top.
   output logic bottom_hit // Counter stands at zero.
);

   tcu_pkg::tcu_top_st_t st_r;
   tcu_pkg::tcu_top_st_t st_nxt;
   tcu_pkg::tcu_class_t cls;
   tcu_pkg::tcu_cmp_ctl_t ctl [2];
   tcu_pkg::tcu_pin_t pins [2];
   logic [2:0] wgm;
   logic [2:0] cs;
   logic tick;
   logic match_clr;
   logic pwm;
   logic [7:0] top_val;
   logic at_top;
   logic at_bottom;
   logic wr_cnt;
   logic step;
   logic wrap;
   logic ovf_set;
   logic flag_wr;
   logic [1:0] com [2];
   logic [1:0] cmp_wr;
   logic [1:0] force_cmp;
   logic [7:0] act [2];
   logic [7:0] rd_val [2];
   logic [1:0] oc;
   logic [1:0] hit;

   // Mode field is split over the two control registers.
   assign wgm = {st_r.ctrl_b[`TCU_CB_WGM2], st_r.ctrl_a[`TCU_CA_WGM_HI:`TCU_CA_WGM_LO]};
   assign cs = st_r.ctrl_b[`TCU_CB_CS_HI:`TCU_CB_CS_LO];
   assign com[0] = st_r.ctrl_a[`TCU_CA_COM_A_HI:`TCU_CA_COM_A_LO];
   assign com[1] = st_r.ctrl_a[`TCU_CA_COM_B_HI:`TCU_CA_COM_B_LO];

   // No source selected means no tick at all, so counting, matches and buffer updates all stop.
   assign tick = tick_in & (cs != `TCU_CS_STOP);

   // Mode decode: low bits 01 are dual slope, 11 single slope, the rest plain.
   always_comb begin
      if (wgm[1:0] == 2'h1) begin
         cls = tcu_pkg::TCU_PHASE;
      end else if (wgm[1:0] == 2'h3) begin
         cls = tcu_pkg::TCU_FAST;
      end else begin
         cls = tcu_pkg::TCU_NONPWM;
      end
   end

   assign match_clr = (wgm == `TCU_MODE_MCLR);
   assign pwm = (cls != tcu_pkg::TCU_NONPWM);
   // Top is compare value A in clear-on-match and high-bit PWM modes, else the maximum.
   assign top_val = ((pwm && wgm[2]) || match_clr) ? act[0] : `TCU_MAX;
   assign at_top = (st_r.cnt == top_val);
   assign at_bottom = (st_r.cnt == `TCU_BOTTOM);
   assign top_hit = at_top;
   assign bottom_hit = at_bottom;

   // Register strobes decoded once for the counter and both channels.
   assign wr_cnt = wr_en && (addr == `TCU_OFS_COUNT);
   assign flag_wr = wr_en && (addr == `TCU_OFS_FLAGS);
   assign cmp_wr[0] = wr_en && (addr == `TCU_OFS_CMP_A);
   assign cmp_wr[1] = wr_en && (addr == `TCU_OFS_CMP_B);
   // Force strobes only work outside PWM modes and are never stored.
   assign force_cmp[0] = wr_en && (addr == `TCU_OFS_CTRL_B) && !pwm
                         && wdata[`TCU_CB_FORCE_A];
   assign force_cmp[1] = wr_en && (addr == `TCU_OFS_CTRL_B) && !pwm
                         && wdata[`TCU_CB_FORCE_B];

   // A tick that meets a count write is dropped, the write wins.
   assign step = tick & ~wr_cnt;
   assign wrap = (cls == tcu_pkg::TCU_FAST) && step && at_top;

   // Overflow point per mode: max in plain modes, top in fast, bottom in dual slope.
   always_comb begin
      unique case (cls)
         tcu_pkg::TCU_NONPWM: ovf_set = step && (st_r.cnt == `TCU_MAX);
         tcu_pkg::TCU_FAST: ovf_set = step && at_top;
         tcu_pkg::TCU_PHASE: ovf_set = step && st_r.down && at_bottom;
         default: ovf_set = 1'b0;
      endcase
   end

   // Two compare channels with their pin overrides.
   generate
      for (genvar i = 0; i < 2; i++) begin : g_chan
         always_comb begin
            ctl[i].tick = tick;
            ctl[i].blocked = st_r.blocked;
            ctl[i].buffered = pwm;
            ctl[i].update = pwm && tick && at_top;
            ctl[i].wr = cmp_wr[i];
            ctl[i].wdata = wdata;
            ctl[i].count = st_r.cnt;
            ctl[i].force_cmp = force_cmp[i];
            ctl[i].com = com[i];
            ctl[i].cls = cls;
            ctl[i].down = st_r.down;
            ctl[i].wrap = wrap;
            ctl[i].toggle_ok = (i == 0) && wgm[2];
         end
         tcu_cmp_chan u_chan (
            .clk(clk),
            .arst_n(arst_n),
            .ctl(ctl[i]),
            .act(act[i]),
            .rd_val(rd_val[i]),
            .oc(oc[i]),
            .hit(hit[i])
         );
         tcu_pin_mux u_pin (
            .com(com[i]),
            .oc(oc[i]),
            .port_out(port_out[i]),
            .port_dir(port_dir[i]),
            .pin(pins[i])
         );
      end
   endgenerate

   assign pin_a = pins[0];
   assign pin_b = pins[1];
   assign rdata = st_r.rdata;
   assign irq_req = {st_r.cflag, st_r.ovf} & st_r.mask;

   // Next state: counter, direction, blocking, flags, control and read data.
   always_comb begin
      st_nxt = st_r;
      // Counting sequence for each mode.
      if (step) begin
         unique case (cls)
            tcu_pkg::TCU_NONPWM: begin
               if (match_clr && (st_r.cnt == act[0])) begin
                  st_nxt.cnt = `TCU_BOTTOM;
               end else begin
                  st_nxt.cnt = st_r.cnt + 8'h01;
               end
            end
            tcu_pkg::TCU_FAST: begin
               st_nxt.cnt = at_top ? `TCU_BOTTOM : st_r.cnt + 8'h01;
            end
            tcu_pkg::TCU_PHASE: begin
               if (st_r.down) begin
                  if (at_bottom) begin
                     st_nxt.down = 1'b0;
                     st_nxt.cnt = st_r.cnt + 8'h01;
                  end else begin
                     st_nxt.cnt = st_r.cnt - 8'h01;
                  end
               end else if (at_top) begin
                  st_nxt.down = 1'b1;
                  st_nxt.cnt = st_r.cnt - 8'h01;
               end else begin
                  st_nxt.cnt = st_r.cnt + 8'h01;
               end
            end
            default: st_nxt.cnt = st_r.cnt;
         endcase
      end
      // Leaving dual slope must not leave the counter heading down.
      if (cls != tcu_pkg::TCU_PHASE) begin
         st_nxt.down = 1'b0;
      end
      if (wr_cnt) begin
         st_nxt.cnt = wdata;
      end
      // A count write arms the block; the next tick consumes it, so it stays armed while stopped.
      if (wr_cnt) begin
         st_nxt.blocked = 1'b1;
      end else if (tick) begin
         st_nxt.blocked = 1'b0;
      end
      // Flags: clear by write of one or by interrupt taken; a new set wins.
      st_nxt.ovf = ovf_set | (st_r.ovf & ~(flag_wr & wdata[`TCU_FL_OVF]) & ~irq_ack[0]);
      st_nxt.cflag[0] = hit[0] | (st_r.cflag[0] & ~(flag_wr & wdata[`TCU_FL_CMP_A])
                        & ~irq_ack[1]);
      st_nxt.cflag[1] = hit[1] | (st_r.cflag[1] & ~(flag_wr & wdata[`TCU_FL_CMP_B])
                        & ~irq_ack[2]);
      // Control registers; output mode bits take effect at once.
      if (wr_en && addr == `TCU_OFS_CTRL_A) begin
         st_nxt.ctrl_a = wdata;
      end
      if (wr_en && addr == `TCU_OFS_CTRL_B) begin
         st_nxt.ctrl_b = wdata[3:0];
      end
      if (wr_en && addr == `TCU_OFS_MASK) begin
         st_nxt.mask = wdata[2:0];
      end
      // Read data stand for one cycle after the strobe, else zero.
      st_nxt.rdata = `TCU_RST_BYTE;
      if (rd_en) begin
         unique case (addr)
            `TCU_OFS_CTRL_A: st_nxt.rdata = st_r.ctrl_a;
            `TCU_OFS_CTRL_B: st_nxt.rdata = {4'h0, st_r.ctrl_b};
            `TCU_OFS_COUNT: st_nxt.rdata = st_r.cnt;
            `TCU_OFS_CMP_A: st_nxt.rdata = rd_val[0];
            `TCU_OFS_CMP_B: st_nxt.rdata = rd_val[1];
            `TCU_OFS_FLAGS: st_nxt.rdata = {5'h00, st_r.cflag, st_r.ovf};
            `TCU_OFS_MASK: st_nxt.rdata = {5'h00, st_r.mask};
            default: st_nxt.rdata = `TCU_RST_BYTE;
         endcase
      end
   end

   // State register.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   // Counter must not move without a selected source.
   a_stop_holds: assert property ((cs == `TCU_CS_STOP) && !wr_cnt |=> $stable(st_r.cnt))
      else $error("Counter moved while stopped.");

   // A count write lands even when a tick coincides.
   a_write_wins: assert property (wr_cnt |=> st_r.cnt == $past(wdata))
      else $error("Count write lost.");

   // Normal mode wraps from max to zero and sets overflow together.
   a_normal_wrap: assert property ((wgm == `TCU_MODE_NORMAL) && step && st_r.cnt == `TCU_MAX
      |=> st_r.cnt == `TCU_BOTTOM && st_r.ovf)
      else $error("Normal mode wrap wrong.");

   // Normal mode counts up by exactly one per tick.
   a_normal_step: assert property ((wgm == `TCU_MODE_NORMAL) && step && st_r.cnt != `TCU_MAX
      |=> st_r.cnt == $past(st_r.cnt) + 8'h01)
      else $error("Normal mode step wrong.");

   // An unblocked match at a tick raises compare flag A.
   a_flag_a_set: assert property (tick && st_r.cnt == act[0] && !st_r.blocked |=> st_r.cflag[0])
      else $error("Compare flag A not set.");

   // A tick in the cycle right after a count write sees no match at all.
   a_write_block: assert property (wr_cnt ##1 (tick && !wr_cnt) |-> hit == 2'b00)
      else $error("Match not blocked after count write.");

   // Writing one clears flag B when no new match arrives.
   a_flag_b_clr: assert property (flag_wr && wdata[`TCU_FL_CMP_B] && !hit[1] |=> !st_r.cflag[1])
      else $error("Compare flag B not cleared.");

   // Writing zero leaves flag A alone.
   a_flag_a_keep: assert property (st_r.cflag[0] && flag_wr && !wdata[`TCU_FL_CMP_A] && !irq_ack[1]
      |=> st_r.cflag[0])
      else $error("Compare flag A lost on zero write.");

   // Pin A shows the output state whenever its mode is nonzero.
   a_pin_override: assert property (com[0] != 2'h0 |-> pin_a.out == oc[0])
      else $error("Pin A not overridden.");

   // Pin B enable follows only the port direction bit.
   a_pin_dir: assert property (pin_b.oe == port_dir[1])
      else $error("Pin B direction not from port.");

   // Interrupt taken clears overflow unless it is set again.
   a_ack_clear: assert property (irq_ack[0] && !ovf_set |=> !st_r.ovf)
      else $error("Overflow flag not cleared on acknowledge.");

endmodule

/* File: shared/tcu_defines.svh */
// Register offsets, field positions and reset values of the timer count and compare unit.
//
// Contract
// - Each tick clears, increments or decrements the counter as the mode requires.
// - Clock source select zero gives no ticks; the counter stays stopped.
// - Software can read and write the count value at any time.
// - A software count write beats any clear or count in that cycle.
// - Mode field: two bits in control A, top bit in control B.
// - Overflow flag sets at a mode dependent point and can request interrupt.
// - Count is compared with both compare values; equality signals a match.
// - A match sets its compare flag on the following tick.
// - Enabled flag requests interrupt; flag clears when the interrupt is taken.
// - Writing one to a compare flag bit clears it; zero leaves it.
// - PWM modes double buffer compare values, updated at top; others do not.
// - Buffered: software reaches the buffer; unbuffered: the active compare value.
// - Non-PWM force strobe acts like a match on output only.
// - A count write blocks every compare match at the next tick.
// - Output mode bits act at the first match after they are written.
// - Reset clears each compare output state.
// - Nonzero output mode puts the compare output state on the pin.
// - Pin direction stays with the port direction bit.
// - Output mode zero leaves the output state unchanged on a match.
// - Output states keep their values across mode changes.
// - Counter gives bottom indication at zero and top indication at top.
// - Maximum is 0xff; top is maximum or compare value A by mode.
// - Normal mode counts up, wraps 0xff to 0x00, overflow sets then.
`ifndef TCU_DEFINES_SVH
`define TCU_DEFINES_SVH

`define TCU_OFS_CTRL_A 3'h0
`define TCU_OFS_CTRL_B 3'h1
`define TCU_OFS_COUNT 3'h2
`define TCU_OFS_CMP_A 3'h3
`define TCU_OFS_CMP_B 3'h4
`define TCU_OFS_FLAGS 3'h5
`define TCU_OFS_MASK 3'h6

`define TCU_CA_COM_A_HI 7
`define TCU_CA_COM_A_LO 6
`define TCU_CA_COM_B_HI 5
`define TCU_CA_COM_B_LO 4
`define TCU_CA_WGM_HI 1
`define TCU_CA_WGM_LO 0
`define TCU_CB_FORCE_A 7
`define TCU_CB_FORCE_B 6
`define TCU_CB_WGM2 3
`define TCU_CB_CS_HI 2
`define TCU_CB_CS_LO 0
`define TCU_FL_OVF 0
`define TCU_FL_CMP_A 1
`define TCU_FL_CMP_B 2

`define TCU_MAX 8'hff
`define TCU_BOTTOM 8'h00
`define TCU_MODE_NORMAL 3'h0
`define TCU_MODE_MCLR 3'h2
`define TCU_CS_STOP 3'h0
`define TCU_RST_BYTE 8'h00

`endif

/* File: shared/tcu_pkg.sv */
// Types shared by the timer count and compare unit.
package tcu_pkg;

   typedef enum logic [1:0] {TCU_NONPWM, TCU_FAST, TCU_PHASE} tcu_class_t;

   typedef struct packed {
      logic tick;
      logic blocked;
      logic buffered;
      logic update;
      logic wr;
      logic [7:0] wdata;
      logic [7:0] count;
      logic force_cmp;
      logic [1:0] com;
      tcu_class_t cls;
      logic down;
      logic wrap;
      logic toggle_ok;
   } tcu_cmp_ctl_t;

   typedef struct packed {
      logic [7:0] buf_val;
      logic [7:0] act;
      logic oc;
   } tcu_cmp_st_t;

   typedef struct packed {
      logic out;
      logic oe;
   } tcu_pin_t;

   typedef struct packed {
      logic [7:0] cnt;
      logic down;
      logic blocked;
      logic ovf;
      logic [1:0] cflag;
      logic [7:0] ctrl_a;
      logic [3:0] ctrl_b;
      logic [2:0] mask;
      logic [7:0] rdata;
   } tcu_top_st_t;

endpackage

/* File: rtl/tcu_cmp_chan.sv */
// One compare channel: buffer, active compare value and output state.
`timescale 1ns/1ns
`include "tcu_defines.svh"
module tcu_cmp_chan (
   input wire logic clk, // System clock.
   input wire logic arst_n, // Asynchronous reset, active low.
   input wire tcu_pkg::tcu_cmp_ctl_t ctl, // Control from the counter.
   output logic [7:0] act, // Active compare value.
   output logic [7:0] rd_val, // Value software reads back.
   output logic oc, // Compare output state.
   output logic hit // Unblocked match at this tick.
);

   tcu_pkg::tcu_cmp_st_t st_r;
   tcu_pkg::tcu_cmp_st_t st_nxt;
   logic eq;

   assign act = st_r.act;
   assign oc = st_r.oc;
   // Buffered reads see the buffer so software reads what it wrote.
   assign rd_val = ctl.buffered ? st_r.buf_val : st_r.act;
   assign eq = (ctl.count == st_r.act);
   assign hit = ctl.tick & eq & ~ctl.blocked;

   // Next state: buffer, active value and waveform action.
   always_comb begin
      st_nxt = st_r;
      if (ctl.update) begin
         st_nxt.act = st_r.buf_val;
      end
      if (ctl.wr) begin
         st_nxt.buf_val = ctl.wdata;
         if (!ctl.buffered) begin
            st_nxt.act = ctl.wdata;
         end
      end
      // Output mode is read live, so a new setting acts at the next match.
      unique case (ctl.cls)
         tcu_pkg::TCU_NONPWM: begin
            if (hit || ctl.force_cmp) begin
               unique case (ctl.com)
                  2'h0: st_nxt.oc = st_r.oc;
                  2'h1: st_nxt.oc = ~st_r.oc;
                  2'h2: st_nxt.oc = 1'b0;
                  2'h3: st_nxt.oc = 1'b1;
               endcase
            end
         end
         tcu_pkg::TCU_FAST: begin
            if (hit) begin
               if (ctl.com == 2'h2) st_nxt.oc = 1'b0;
               if (ctl.com == 2'h3) st_nxt.oc = 1'b1;
               if (ctl.com == 2'h1 && ctl.toggle_ok) st_nxt.oc = ~st_r.oc;
            end
            // The bottom action wins so that a compare at top gives a steady level.
            if (ctl.wrap) begin
               if (ctl.com == 2'h2) st_nxt.oc = 1'b1;
               if (ctl.com == 2'h3) st_nxt.oc = 1'b0;
            end
         end
         tcu_pkg::TCU_PHASE: begin
            if (hit) begin
               if (ctl.com == 2'h2) st_nxt.oc = ctl.down;
               if (ctl.com == 2'h3) st_nxt.oc = ~ctl.down;
               if (ctl.com == 2'h1 && ctl.toggle_ok) st_nxt.oc = ~st_r.oc;
            end
         end
         default: st_nxt.oc = st_r.oc;
      endcase
   end

   // State register; mode changes touch neither the output state nor the compare values.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule

/* File: rtl/tcu_pin_mux.sv */
// Port override for one compare output pin.
`timescale 1ns/1ns
module tcu_pin_mux (
   input wire logic [1:0] com, // Compare output mode of this channel.
   input wire logic oc, // Compare output state.
   input wire logic port_out, // General port output value.
   input wire logic port_dir, // Port direction bit, high for output.
   output tcu_pkg::tcu_pin_t pin // Pin output and enable.
);

   // The direction stays with the port even while the timer owns the level.
   always_comb begin
      pin.out = (com != 2'h0) ? oc : port_out;
      pin.oe = port_dir;
   end

endmodule

/* File: bench/tcu_top_tb.sv */
// Self-checking bench for the timer count and compare unit, with a behavioural model.
`timescale 1ns/1ns
`include "tcu_defines.svh"
module tcu_top_tb;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic tick_in = 1'b0;
   logic [2:0] irq_ack = 3'h0;
   logic [1:0] port_out = 2'h2;
   logic [1:0] port_dir = 2'h1;
   logic [7:0] rdata;
   logic [2:0] irq_req;
   tcu_pkg::tcu_pin_t pin_a;
   tcu_pkg::tcu_pin_t pin_b;
   logic top_hit;
   logic bottom_hit;
   int failures = 0;
   int checked = 0;
   // Model state; integers keep the wrap arithmetic explicit.
   int m_cnt, m_act_a, m_buf_a, m_act_b, m_buf_b, v, c;
   logic [7:0] m_ca = 8'h00;
   logic [7:0] m_cb = 8'h00;
   logic [2:0] m_fl = 3'h0;
   logic [2:0] m_mask = 3'h0;
   bit m_blk, m_dn;

   // Free-running 100 MHz clock.
   always #5 clk = ~clk;

   tcu_top u_dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
      .rd_en(rd_en), .rdata(rdata), .tick_in(tick_in), .irq_ack(irq_ack),
      .port_out(port_out), .port_dir(port_dir), .irq_req(irq_req), .pin_a(pin_a),
      .pin_b(pin_b), .top_hit(top_hit), .bottom_hit(bottom_hit));

   // Mode helpers of the model.
   function automatic int mode();
      return {m_cb[3], m_ca[1:0]};
   endfunction
   function automatic bit pwm();
      return mode() % 2 == 1;
   endfunction
   function automatic int top();
      return (mode() == 2 || mode() == 5 || mode() == 7) ? m_act_a : 255;
   endfunction
   function automatic logic [7:0] mrd(logic [2:0] a);
      case (a)
         `TCU_OFS_CTRL_A: return m_ca;
         `TCU_OFS_CTRL_B: return m_cb;
         `TCU_OFS_COUNT: return 8'(m_cnt);
         `TCU_OFS_CMP_A: return 8'(pwm() ? m_buf_a : m_act_a);
         `TCU_OFS_CMP_B: return 8'(pwm() ? m_buf_b : m_act_b);
         `TCU_OFS_FLAGS: return {5'h0, m_fl};
         `TCU_OFS_MASK: return {5'h0, m_mask};
         default: return 8'h00;
      endcase
   endfunction

   // Case equality so that an unknown never passes as a match.
   task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
      checked++;
      if (s !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Level outputs are sampled at the falling edge, well away from any update.
   task automatic hits();
      @(negedge clk);
      chk("top_hit", {7'h0, m_cnt == top()}, {7'h0, top_hit});
      chk("bottom_hit", {7'h0, m_cnt == 0}, {7'h0, bottom_hit});
      chk("irq_req", {5'h0, m_fl & m_mask}, {5'h0, irq_req});
   endtask

   // One model step; the comparison uses the count before the step.
   task automatic m_tick();
      int t;
      bit ha;
      bit hb;
      t = top();
      ha = !m_blk && m_cnt == m_act_a;
      hb = !m_blk && m_cnt == m_act_b;
      m_blk = 0;
      if (ha) m_fl[1] = 1'b1;
      if (hb) m_fl[2] = 1'b1;
      if (pwm() && m_cnt == t) begin
         m_act_a = m_buf_a;
         m_act_b = m_buf_b;
      end
      if (mode() == 3 || mode() == 7) begin
         m_fl[0] |= m_cnt == t;
         m_cnt = (m_cnt == t) ? 0 : m_cnt + 1;
      end else if (pwm()) begin
         if (m_dn && m_cnt == 0) m_fl[0] = 1'b1;
         if (m_cnt == t) m_dn = 1;
         else if (m_cnt == 0) m_dn = 0;
         m_cnt = m_dn ? m_cnt - 1 : m_cnt + 1;
      end else begin
         m_fl[0] |= m_cnt == 255;
         m_cnt = (mode() == 2 && m_cnt == t) ? 0 : (m_cnt + 1) % 256;
      end
   endtask

   // Ticks are spaced one idle cycle apart so every step can be inspected.
   task automatic tk(int n);
      repeat (n) begin
         @(posedge clk);
         tick_in <= 1'b1;
         @(posedge clk);
         tick_in <= 1'b0;
         if (m_cb[2:0] != 3'h0) m_tick();
         hits();
      end
   endtask

   // Register write; t raises a tick in the same cycle.
   task automatic wr(logic [2:0] a, logic [7:0] d, bit t = 0);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      tick_in <= t;
      @(posedge clk);
      wr_en <= 1'b0;
      tick_in <= 1'b0;
      case (a)
         `TCU_OFS_CTRL_A: m_ca = d;
         `TCU_OFS_CTRL_B: m_cb = {4'h0, d[3:0]};
         `TCU_OFS_COUNT: begin
            m_cnt = d;
            m_blk = 1;
         end
         `TCU_OFS_CMP_A: begin
            m_buf_a = d;
            if (!pwm()) m_act_a = d;
         end
         `TCU_OFS_CMP_B: begin
            m_buf_b = d;
            if (!pwm()) m_act_b = d;
         end
         `TCU_OFS_FLAGS: m_fl &= ~d[2:0];
         `TCU_OFS_MASK: m_mask = d[2:0];
         default: ;
      endcase
      if (mode() != 1 && mode() != 5) m_dn = 0;
      hits();
   endtask

   // Register read; data stand only in the cycle after the strobe.
   task automatic rc(logic [2:0] a);
      logic [7:0] e;
      e = mrd(a);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      @(negedge clk);
      chk($sformatf("reg%0d", a), e, rdata);
   endtask

   task automatic ack(logic [2:0] b);
      @(posedge clk);
      irq_ack <= b;
      @(posedge clk);
      irq_ack <= 3'h0;
      m_fl &= ~b;
      hits();
   endtask

   task automatic pc(logic [1:0] ea, logic [1:0] eb);
      @(negedge clk);
      chk("pin_a", {6'h0, ea}, {6'h0, pin_a});
      chk("pin_b", {6'h0, eb}, {6'h0, pin_b});
   endtask

   // Main sequence.
   initial begin
      void'($urandom(32'h84ef));
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      hits();
      pc(2'b01, 2'b10);
      for (int a = 0; a < 8; a++) rc(3'(a));
      v = $urandom_range(8'hef, 8'h10);
      wr(`TCU_OFS_COUNT, 8'(v));
      tk(3);
      rc(`TCU_OFS_COUNT);
      wr(`TCU_OFS_MASK, 8'h07);
      wr(`TCU_OFS_CTRL_B, 8'h01);
      c = $urandom_range(8'h60, 8'h20);
      wr(`TCU_OFS_CMP_A, 8'(c));
      wr(`TCU_OFS_CMP_B, 8'(c + 1));
      wr(`TCU_OFS_COUNT, 8'(c));
      tk(2);
      rc(`TCU_OFS_FLAGS);
      wr(`TCU_OFS_CTRL_B, 8'h00);
      wr(`TCU_OFS_COUNT, 8'(c));
      wr(`TCU_OFS_CTRL_B, 8'h01);
      tk(1);
      rc(`TCU_OFS_FLAGS);
      ack(3'h4);
      wr(`TCU_OFS_FLAGS, 8'h00);
      v = $urandom_range(8'hfc, 8'hf0);
      wr(`TCU_OFS_COUNT, 8'(v));
      tk(257 - v);
      rc(`TCU_OFS_FLAGS);
      ack(3'h1);
      wr(`TCU_OFS_COUNT, 8'h05);
      wr(`TCU_OFS_COUNT, 8'hfe, 1);
      rc(`TCU_OFS_COUNT);
      tk(2);
      wr(`TCU_OFS_FLAGS, 8'h07);
      wr(`TCU_OFS_CMP_A, 8'h04);
      wr(`TCU_OFS_CTRL_A, 8'h02);
      wr(`TCU_OFS_COUNT, 8'h00);
      tk(7);
      rc(`TCU_OFS_COUNT);
      // Output state work: force strobes only, so the counter stays put.
      @(posedge clk);
      port_dir <= 2'b11;
      wr(`TCU_OFS_CTRL_A, 8'h40);
      pc(2'b01, 2'b11);
      wr(`TCU_OFS_CTRL_B, 8'h81);
      pc(2'b11, 2'b11);
      rc(`TCU_OFS_FLAGS);
      rc(`TCU_OFS_COUNT);
      @(posedge clk);
      port_dir <= 2'b10;
      pc(2'b10, 2'b11);
      wr(`TCU_OFS_CTRL_A, 8'h00);
      pc(2'b00, 2'b11);
      wr(`TCU_OFS_CTRL_B, 8'h81);
      wr(`TCU_OFS_CTRL_A, 8'h80);
      pc(2'b10, 2'b11);
      wr(`TCU_OFS_CTRL_B, 8'h81);
      pc(2'b00, 2'b11);
      wr(`TCU_OFS_CTRL_A, 8'h30);
      pc(2'b00, 2'b01);
      wr(`TCU_OFS_CTRL_B, 8'h41);
      wr(`TCU_OFS_CTRL_A, 8'h33);
      pc(2'b00, 2'b11);
      // Fast mode with top from compare A; the new value waits for top.
      wr(`TCU_OFS_CTRL_A, 8'h03);
      wr(`TCU_OFS_CTRL_B, 8'h09);
      wr(`TCU_OFS_COUNT, 8'h00);
      wr(`TCU_OFS_CMP_A, 8'h06);
      rc(`TCU_OFS_CMP_A);
      tk(12);
      rc(`TCU_OFS_FLAGS);
      // Dual slope: turn at top, overflow at bottom while counting down.
      wr(`TCU_OFS_CTRL_B, 8'h01);
      wr(`TCU_OFS_CTRL_A, 8'h01);
      wr(`TCU_OFS_COUNT, 8'hfd);
      tk(4);
      wr(`TCU_OFS_COUNT, 8'h02);
      tk(4);
      rc(`TCU_OFS_FLAGS);
      // Dual slope with top from compare A; the inverted match sets the state while rising.
      wr(`TCU_OFS_CTRL_A, 8'hc1);
      wr(`TCU_OFS_CTRL_B, 8'h09);
      tk(10);
      pc(2'b10, 2'b11);
      rc(`TCU_OFS_FLAGS);
      // Mode bits 100 count as a plain mode for the random run below.
      wr(`TCU_OFS_CTRL_A, 8'h00);
      for (int i = 0; i < 6; i++) begin
         wr(`TCU_OFS_COUNT, 8'($urandom));
         tk($urandom_range(40, 1));
         rc(`TCU_OFS_FLAGS);
         rc(`TCU_OFS_COUNT);
      end
      test_done();
   end

   // Watchdog: a hang counts as a mismatch and ends the run.
   initial begin
      #200000;
      failures++;
      test_done();
   end
endmodule
